// >>> inc/remap_defs.svh
`ifndef REMAP_DEFS_SVH
`define REMAP_DEFS_SVH

// Byte offsets of the selection registers and the status register on the register bus
`define RSB_OFF_SEL13   12'h000
`define RSB_OFF_SEL14   12'h004
`define RSB_OFF_SEL16   12'h00C
`define RSB_OFF_SEL17   12'h010
`define RSB_OFF_STATUS  12'h014

// Selector field positions inside each 16-bit selection register
`define RSB_LO_MSB      5
`define RSB_LO_LSB      0
`define RSB_HI_MSB      13
`define RSB_HI_LSB      8

// Byte lanes that carry the two selector fields
`define RSB_STRB_LO     0
`define RSB_STRB_HI     1

// Reset value of every selector field, and the code meaning no function
`define RSB_SEL_RESET   6'h00
`define RSB_CODE_NONE   6'h00

// Status register layout
`define RSB_STAT_VARIANT_BIT 8

// Remappable pins handled here: 26, 27, 28, 29, 32, 33, 34, 35
`define RSB_NUM_PINS    8
`define RSB_NUM_SLOTS   4
`define RSB_NUM_FUNCS   64

`endif

// >>> inc/remap_pkg.sv
package remap_pkg;

   // One six-bit peripheral function code
   typedef logic [5:0] sel_code_t;

   // Field pair held by one selection register
   typedef struct packed {
      sel_code_t hi;
      sel_code_t lo;
   } pair_sel_t;

   // Register selected by the current bus address
   typedef enum logic [2:0] {
      SLOT_13,
      SLOT_14,
      SLOT_16,
      SLOT_17,
      SLOT_STATUS,
      SLOT_NONE
   } reg_slot_t;

endpackage

// >>> inc/pin_sel_if.sv
// Selector code going out to one pin multiplexer and its state coming back
interface pin_sel_if;
   remap_pkg::sel_code_t code;
   logic                 pin_level;
   logic                 remapped;

   modport bank (output code, input pin_level, input remapped);
   modport mux  (input code, output pin_level, output remapped);
endinterface

// >>> hdl/pin_output_mux.sv
`include "remap_defs.svh"

module pin_output_mux (
   input  wire logic        ref_clk_i,
   input  wire logic        resetn_i,
   input  wire logic [63:0] periph_out_i,
   input  wire logic [63:0] fn_present_i,
   input  wire logic        port_data_i,
   pin_sel_if.mux           sel
);

   logic level;
   logic used;

   // Code in use only if nonzero and the function table defines it
   wire code_used  = (sel.code != `RSB_CODE_NONE) && fn_present_i[sel.code];
   // Peripheral signal when mapped, otherwise the ordinary port latch
   wire next_level = code_used ? periph_out_i[sel.code] : port_data_i;

   // Registered pin drive
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         level <= 1'b0;
         used  <= 1'b0;
      end else begin
         level <= next_level;
         used  <= code_used;
      end
   end

   assign sel.pin_level = level;
   assign sel.remapped  = used;

endmodule

// >>> hdl/remap_output_select_bank.sv
// What this block does
// - Upper six-bit field selects the function driving the odd pin of the pair.
// - Lower six-bit field selects the function driving the even pin of the pair.
// - Bits 15-14 and 7-6 ignore writes and read as zero.
// - Sixteenth register upper field, read/write, reset zero, drives pin 33.
// - Sixteenth register lower field, read/write, reset zero, drives pin 32.
// - Seventeenth register fields drive pins 35 and 34, six bits, reset zero.
// - Thirteenth and fourteenth registers and their pins exist only on large packages.
`include "remap_defs.svh"

module remap_output_select_bank #(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   input  wire logic        ref_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [63:0] periph_out_i,
   input  wire logic [63:0] fn_present_i,
   input  wire logic [7:0]  port_data_i,
   output logic      [7:0]  pin_out_o,
   output logic      [7:0]  pin_remapped_o
);

   // Selector storage for registers 13 and 14, one variable per field
   remap_pkg::sel_code_t sel_13_lo;
   remap_pkg::sel_code_t sel_13_hi;
   remap_pkg::sel_code_t sel_14_lo;
   remap_pkg::sel_code_t sel_14_hi;

   // Selector storage for registers 16 and 17, each field with a single writer
   remap_pkg::sel_code_t sel_16_lo;
   remap_pkg::sel_code_t sel_16_hi;
   remap_pkg::sel_code_t sel_17_lo;
   remap_pkg::sel_code_t sel_17_hi;

   // Registered bus answer
   logic [31:0] rdata_q;
   logic        err_q;

   // Per-pin carriers to the multiplexers
   pin_sel_if pin_if [`RSB_NUM_PINS] ();

   // Status gathered back from the multiplexers
   logic [7:0] remapped_vec;
   logic [7:0] level_vec;

   // Address decode
   remap_pkg::reg_slot_t slot;
   assign slot = (paddr_i == `RSB_OFF_SEL13)  ? remap_pkg::SLOT_13 :
                 (paddr_i == `RSB_OFF_SEL14)  ? remap_pkg::SLOT_14 :
                 (paddr_i == `RSB_OFF_SEL16)  ? remap_pkg::SLOT_16 :
                 (paddr_i == `RSB_OFF_SEL17)  ? remap_pkg::SLOT_17 :
                 (paddr_i == `RSB_OFF_STATUS) ? remap_pkg::SLOT_STATUS :
                                                remap_pkg::SLOT_NONE;

   // Slot index of a selection register, and whether the variant has it
   wire [1:0] slot_idx   = (slot == remap_pkg::SLOT_13) ? 2'h0 :
                           (slot == remap_pkg::SLOT_14) ? 2'h1 :
                           (slot == remap_pkg::SLOT_16) ? 2'h2 : 2'h3;
   wire       is_sel     = (slot == remap_pkg::SLOT_13) || (slot == remap_pkg::SLOT_14) ||
                           (slot == remap_pkg::SLOT_16) || (slot == remap_pkg::SLOT_17);
   wire       big_only   = (slot == remap_pkg::SLOT_13) || (slot == remap_pkg::SLOT_14);
   wire       sel_exists = is_sel && (LARGE_PACKAGE || !big_only);

   // Bus phases
   wire setup_ph  = psel_i && !penable_i;
   wire access_ph = psel_i && penable_i;

   // Errors: missing register, unmapped address, write to status
   wire bad_status_wr = (slot == remap_pkg::SLOT_STATUS) && pwrite_i;
   wire next_err      = !(sel_exists || (slot == remap_pkg::SLOT_STATUS)) || bad_status_wr;

   // Write strobes per field, only in the access phase of a good write
   wire wr_ok  = access_ph && pwrite_i && !err_q;
   wire wr_lo  = wr_ok && pstrb_i[`RSB_STRB_LO];
   wire wr_hi  = wr_ok && pstrb_i[`RSB_STRB_HI];

   // Field values carried by the write data; the unused bits are dropped
   wire [5:0] wdata_lo = pwdata_i[`RSB_LO_MSB:`RSB_LO_LSB];
   wire [5:0] wdata_hi = pwdata_i[`RSB_HI_MSB:`RSB_HI_LSB];

   // Read word of the addressed selection register, gaps read as zero
   remap_pkg::pair_sel_t rd_pair;
   assign rd_pair = (slot_idx == 2'h0) ? {sel_13_hi, sel_13_lo} :
                    (slot_idx == 2'h1) ? {sel_14_hi, sel_14_lo} :
                    (slot_idx == 2'h2) ? {sel_16_hi, sel_16_lo} :
                                         {sel_17_hi, sel_17_lo};
   wire [31:0] sel_word    = {16'h0000, 2'b00, rd_pair.hi, 2'b00, rd_pair.lo};

   // Status word: large-package flag and which pins a peripheral owns
   wire [31:0] status_word = {23'h000000, LARGE_PACKAGE, remapped_vec};

   wire [31:0] next_rdata  = (!setup_ph || pwrite_i || next_err) ? 32'h00000000 :
                             (slot == remap_pkg::SLOT_STATUS)     ? status_word :
                                                                    sel_word;

   // Write hits per selection register; an absent register never matches,
   // so a refused write leaves every field untouched
   wire hit_13 = sel_exists && (slot_idx == 2'h0);
   wire hit_14 = sel_exists && (slot_idx == 2'h1);

   // Registers present on every variant
   wire hit_16 = sel_exists && (slot_idx == 2'h2);
   wire hit_17 = sel_exists && (slot_idx == 2'h3);

   // Register 13 lower field, pin 26
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_13_lo <= `RSB_SEL_RESET;
      end else if (wr_lo && hit_13) begin
         sel_13_lo <= wdata_lo;
      end
   end

   // Register 13 upper field, pin 27
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_13_hi <= `RSB_SEL_RESET;
      end else if (wr_hi && hit_13) begin
         sel_13_hi <= wdata_hi;
      end
   end

   // Register 14 lower field, pin 28
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_14_lo <= `RSB_SEL_RESET;
      end else if (wr_lo && hit_14) begin
         sel_14_lo <= wdata_lo;
      end
   end

   // Register 14 upper field, pin 29
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_14_hi <= `RSB_SEL_RESET;
      end else if (wr_hi && hit_14) begin
         sel_14_hi <= wdata_hi;
      end
   end

   // Register 16 lower field, pin 32
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_16_lo <= `RSB_SEL_RESET;
      end else if (wr_lo && hit_16) begin
         sel_16_lo <= wdata_lo;
      end
   end

   // Register 16 upper field, pin 33
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_16_hi <= `RSB_SEL_RESET;
      end else if (wr_hi && hit_16) begin
         sel_16_hi <= wdata_hi;
      end
   end

   // Register 17 lower field, pin 34
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_17_lo <= `RSB_SEL_RESET;
      end else if (wr_lo && hit_17) begin
         sel_17_lo <= wdata_lo;
      end
   end

   // Register 17 upper field, pin 35
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_17_hi <= `RSB_SEL_RESET;
      end else if (wr_hi && hit_17) begin
         sel_17_hi <= wdata_hi;
      end
   end

   // Answer captured in the setup phase, shown in the access phase
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= 32'h00000000;
         err_q   <= 1'b0;
      end else if (setup_ph) begin
         rdata_q <= next_rdata;
         err_q   <= next_err;
      end
   end

   // Zero wait states
   assign pready_o  = 1'b1;
   assign pslverr_o = access_ph && err_q;
   assign prdata_o  = rdata_q;

   // Codes for pins 26 to 29; without the large package they stay on
   // ordinary port control, whatever the absent registers would hold
   assign pin_if[0].code = LARGE_PACKAGE ? sel_13_lo : `RSB_CODE_NONE;
   assign pin_if[1].code = LARGE_PACKAGE ? sel_13_hi : `RSB_CODE_NONE;
   assign pin_if[2].code = LARGE_PACKAGE ? sel_14_lo : `RSB_CODE_NONE;
   assign pin_if[3].code = LARGE_PACKAGE ? sel_14_hi : `RSB_CODE_NONE;

   // Codes for pins 32 to 35, present on every variant
   assign pin_if[4].code = sel_16_lo;
   assign pin_if[5].code = sel_16_hi;
   assign pin_if[6].code = sel_17_lo;
   assign pin_if[7].code = sel_17_hi;

   // Status and levels gathered back from the eight multiplexers
   assign remapped_vec = {pin_if[7].remapped, pin_if[6].remapped, pin_if[5].remapped,
                          pin_if[4].remapped, pin_if[3].remapped, pin_if[2].remapped,
                          pin_if[1].remapped, pin_if[0].remapped};
   assign level_vec    = {pin_if[7].pin_level, pin_if[6].pin_level, pin_if[5].pin_level,
                          pin_if[4].pin_level, pin_if[3].pin_level, pin_if[2].pin_level,
                          pin_if[1].pin_level, pin_if[0].pin_level};

   // Pin 26 multiplexer, lower field of register 13
   pin_output_mux u_mux_26 (
      .ref_clk_i    (ref_clk_i),
      .resetn_i     (resetn_i),
      .periph_out_i (periph_out_i),
      .fn_present_i (fn_present_i),
      .port_data_i  (port_data_i[0]),
      .sel          (pin_if[0])
   );

   // Pin 27 multiplexer, upper field of register 13
   pin_output_mux u_mux_27 (
      .ref_clk_i    (ref_clk_i),
      .resetn_i     (resetn_i),
      .periph_out_i (periph_out_i),
      .fn_present_i (fn_present_i),
      .port_data_i  (port_data_i[1]),
      .sel          (pin_if[1])
   );

   // Pin 28 multiplexer, lower field of register 14
   pin_output_mux u_mux_28 (
      .ref_clk_i    (ref_clk_i),
      .resetn_i     (resetn_i),
      .periph_out_i (periph_out_i),
      .fn_present_i (fn_present_i),
      .port_data_i  (port_data_i[2]),
      .sel          (pin_if[2])
   );

   // Pin 29 multiplexer, upper field of register 14
   pin_output_mux u_mux_29 (
      .ref_clk_i    (ref_clk_i),
      .resetn_i     (resetn_i),
      .periph_out_i (periph_out_i),
      .fn_present_i (fn_present_i),
      .port_data_i  (port_data_i[3]),
      .sel          (pin_if[3])
   );

   // Pin 32 multiplexer, lower field of register 16
   pin_output_mux u_mux_32 (
      .ref_clk_i    (ref_clk_i),
      .resetn_i     (resetn_i),
      .periph_out_i (periph_out_i),
      .fn_present_i (fn_present_i),
      .port_data_i  (port_data_i[4]),
      .sel          (pin_if[4])
   );

   // Pin 33 multiplexer, upper field of register 16
   pin_output_mux u_mux_33 (
      .ref_clk_i    (ref_clk_i),
      .resetn_i     (resetn_i),
      .periph_out_i (periph_out_i),
      .fn_present_i (fn_present_i),
      .port_data_i  (port_data_i[5]),
      .sel          (pin_if[5])
   );

   // Pin 34 multiplexer, lower field of register 17
   pin_output_mux u_mux_34 (
      .ref_clk_i    (ref_clk_i),
      .resetn_i     (resetn_i),
      .periph_out_i (periph_out_i),
      .fn_present_i (fn_present_i),
      .port_data_i  (port_data_i[6]),
      .sel          (pin_if[6])
   );

   // Pin 35 multiplexer, upper field of register 17
   pin_output_mux u_mux_35 (
      .ref_clk_i    (ref_clk_i),
      .resetn_i     (resetn_i),
      .periph_out_i (periph_out_i),
      .fn_present_i (fn_present_i),
      .port_data_i  (port_data_i[7]),
      .sel          (pin_if[7])
   );

   // Pin drives come straight from the multiplexer flip-flops
   assign pin_out_o      = level_vec;
   assign pin_remapped_o = remapped_vec;

endmodule

// >>> testbench/remap_bank_checker.sv
module remap_bank_checker #(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   input wire logic        ref_clk_i,
   input wire logic        resetn_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [7:0]  port_data_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pslverr_o,
   input wire logic [7:0]  pin_out_o,
   input wire logic [7:0]  pin_remapped_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // Access phase and address decode
   wire acc = psel_i & penable_i;
   wire rd  = acc & ~pwrite_i;
   wire low = paddr_i == 12'h000 | paddr_i == 12'h004;
   wire hit = low | paddr_i == 12'h00C | paddr_i == 12'h010;
   // Bus and pin relations
   property p_rsvd; rd && hit |-> (prdata_o & 32'hFFFF_C0C0) == 32'h0; endproperty
   property p_small; acc && low && !LARGE_PACKAGE |-> pslverr_o; endproperty
   property p_large; acc && hit && LARGE_PACKAGE |-> !pslverr_o; endproperty
   property p_hole; rd && pslverr_o |-> prdata_o == 32'h0; endproperty
   property p_phase; pslverr_o |-> acc; endproperty
   property p_port; $past(resetn_i) |->
      ((pin_out_o ^ $past(port_data_i)) & ~pin_remapped_o) == 8'h0; endproperty
   property p_stat; rd && paddr_i == 12'h014 |->
      prdata_o[8:0] == {LARGE_PACKAGE, $past(pin_remapped_o)}; endproperty
   property p_fixed; !LARGE_PACKAGE |-> pin_remapped_o[3:0] == 4'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   a_small: assert property (p_small) else $error("absent reg accepted");
   a_large: assert property (p_large) else $error("mapped reg refused");
   a_hole: assert property (p_hole) else $error("error read not zero");
   a_phase: assert property (p_phase) else $error("error outside access");
   a_port: assert property (p_port) else $error("pin not on port");
   a_stat: assert property (p_stat) else $error("status mismatch");
   a_fixed: assert property (p_fixed) else $error("absent pin remapped");
   c_write: cover property (acc && pwrite_i && hit);
   c_error: cover property (pslverr_o);
   c_remap: cover property (pin_remapped_o != 8'h0);
endmodule

bind remap_output_select_bank remap_bank_checker #(.LARGE_PACKAGE(LARGE_PACKAGE)) chk (
   .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .port_data_i(port_data_i), .prdata_o(prdata_o),
   .pslverr_o(pslverr_o), .pin_out_o(pin_out_o), .pin_remapped_o(pin_remapped_o));

// >>> testbench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [3:0]  pstrb_i = 4'hF;
   logic [63:0] periph_out_i = 64'h0;
   logic [63:0] fn_present_i = 64'h0;
   logic [7:0]  port_data_i = 8'hA5;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        s_err;
   logic [7:0]  pin_out_o;
   logic [7:0]  pin_remapped_o;
   logic [31:0] rdat;
   logic [1:0]  errs;
   logic [11:0] addrs [4] = '{12'h000, 12'h004, 12'h00C, 12'h010};
   int          bad_count = 0;
   int          compares = 0;
   // 25 MHz clock
   always #20 ref_clk_i = ~ref_clk_i;
   remap_output_select_bank dut (.*);
   remap_output_select_bank #(.LARGE_PACKAGE(1'b0)) dut_small (.*, .prdata_o(),
      .pready_o(), .pslverr_o(s_err), .pin_out_o(), .pin_remapped_o());
   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic conclude();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One APB transfer: setup, access until pready at a rising edge, then release
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= s;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      @(posedge ref_clk_i);
      while (pready_o !== 1'b1) begin
         n++;
         if (n > 16) begin
            bad_count++;
            conclude();
         end
         @(posedge ref_clk_i);
      end
      rdat = prdata_o;
      errs = {pslverr_o, s_err};
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic idle(input int n);
      @(posedge ref_clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      repeat (n) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask
   task automatic t_reset();
      foreach (addrs[i]) begin
         apb(1'b0, addrs[i], 32'h0, 4'hF);
         check(32'h0, rdat);
      end
      idle(1);
      check(32'hA5, {24'h0, pin_out_o});
      $display("reset test done");
   endtask
   task automatic t_fields();
      foreach (addrs[i]) begin
         apb(1'b1, addrs[i], 32'hFFFF_FFFF, 4'hF);
         apb(1'b0, addrs[i], 32'h0, 4'hF);
         check(32'h0000_3F3F, rdat);
         apb(1'b1, addrs[i], 32'h0000_2A15 + i, 4'h1);
         apb(1'b0, addrs[i], 32'h0, 4'hF);
         check(32'h0000_3F15 + i, rdat);
         apb(1'b1, addrs[i], 32'h0000_2A00, 4'h2);
         apb(1'b0, addrs[i], 32'h0, 4'hF);
         check(32'h0000_2A15 + i, rdat);
         apb(1'b1, addrs[i], 32'h0, 4'hF);
      end
      idle(1);
      $display("field test done");
   endtask
   task automatic t_pins();
      @(posedge ref_clk_i);
      fn_present_i <= 64'hFFFF_FFFF_FFFF_FDFF;
      periph_out_i <= 64'h0000_0000_0000_02A0;
      port_data_i <= 8'h24;
      apb(1'b1, 12'h00C, 32'h0000_3F05, 4'hF);
      apb(1'b1, 12'h010, 32'h0000_0709, 4'hF);
      apb(1'b1, 12'h004, 32'h0000_0700, 4'hF);
      idle(2);
      check(32'h9C, {24'h0, pin_out_o});
      check(32'hB8, {24'h0, pin_remapped_o});
      apb(1'b0, 12'h014, 32'h0, 4'hF);
      check(32'h0000_01B8, rdat);
      idle(1);
      $display("pin test done");
   endtask
   task automatic t_errors();
      apb(1'b0, 12'h008, 32'h0, 4'hF);
      check(32'h3, {30'h0, errs});
      check(32'h0, rdat);
      apb(1'b1, 12'h000, 32'h0000_0101, 4'hF);
      check(32'h1, {30'h0, errs});
      apb(1'b0, 12'h000, 32'h0, 4'hF);
      check(32'h0000_0101, rdat);
      check(32'h1, {30'h0, errs});
      apb(1'b1, 12'h014, 32'h0, 4'hF);
      check(32'h3, {30'h0, errs});
      idle(1);
      $display("error test done");
   endtask
   // Reset for 8 cycles, then the scenarios
   initial begin
      repeat (8) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      t_reset();
      t_fields();
      t_pins();
      t_errors();
      conclude();
   end
endmodule
